// ==== dtg_cpu_model.sv ====
/* dtg_cpu_model: CPU core side of dtg_top, one bus event per go request.
   Assumes: go, kind and addr change just after a clk_sys edge. */
`timescale 1ns/10ps
module dtg_cpu_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [4:0] kind,
  input wire logic [15:0] addr,
  output logic acc_valid,
  output logic [15:0] acc_addr,
  output logic [7:0] acc_data,
  output logic match_a,
  output logic match_b,
  output logic exec_valid,
  output logic [15:0] exec_addr,
  output logic exec_a,
  output logic exec_b,
  output logic cof_valid,
  output logic [15:0] cof_addr
);
  logic [4:0] ev_r;
  logic [15:0] addr_r;
  // idle buses toggle so a stale address never looks valid
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ev_r <= 5'h00;
      addr_r <= 16'h0000;
    end else begin
      ev_r <= go ? kind : 5'h00;
      addr_r <= go ? addr : ~addr_r;
    end
  end
  // kind: 0 hit a, 1 hit b, 2 hit is an executed opcode, 3 flow change, 4 plain access
  assign acc_valid = (ev_r[4] | ev_r[1] | ev_r[0]) & ~ev_r[2];
  assign match_a = ev_r[0] & ~ev_r[2];
  assign match_b = ev_r[1] & ~ev_r[2];
  assign exec_valid = ev_r[2];
  assign exec_a = ev_r[0] & ev_r[2];
  assign exec_b = ev_r[1] & ev_r[2];
  assign cof_valid = ev_r[3];
  assign acc_addr = addr_r;
  assign acc_data = addr_r[7:0];
  assign exec_addr = addr_r;
  assign cof_addr = addr_r;
endmodule : dtg_cpu_model

// ==== dtg_fifo.sv ====
/*
 * dtg_fifo: small circular capture store; overwrites the oldest word when
 * full, pops on request unless written in the same cycle, clears on request.
 * Assumes: single clock, synchronous active-high reset.
 */
`timescale 1ns/10ps
module dtg_fifo #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int CW = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  input wire logic wr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic rd,
  output logic [WIDTH-1:0] head,
  output logic [CW-1:0] count,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;

  wire empty = (cnt_r == '0);
  assign full = (cnt_r == CW'(DEPTH));
  wire do_rd = rd & ~empty & ~wr;
  wire ovr = wr & full;

  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem[wp_r] <= wdata;
    end
  end

  // overwrite of the oldest word keeps the latest DEPTH entries
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) wp_r <= wp_r + 1'b1;
      if (ovr || do_rd) rp_r <= rp_r + 1'b1;
      if (wr && !full) cnt_r <= cnt_r + 1'b1;
      else if (do_rd) cnt_r <= cnt_r - 1'b1;
    end
  end

  assign head = empty ? '0 : mem[rp_r];
  assign count = cnt_r;
endmodule : dtg_fifo

// ==== dtg_pkg.sv ====
/*
 * dtg_pkg: register map, field positions, trigger modes and sizes for the
 * debug trigger and status block.
 * Assumes: one clock domain, 8-bit register port with a small word address.
 */
package dtg_pkg;
  // ----------------------------------------------------------------------
  // register map (word addresses on the plain port)
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_TRIG = 3'h1;
  localparam logic [2:0] ADDR_STAT = 3'h2;
  localparam logic [2:0] ADDR_FIFO_HI = 3'h3;
  localparam logic [2:0] ADDR_FIFO_LO = 3'h4;
  localparam logic [2:0] ADDR_IRQ_ST = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MSK = 3'h6;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN = 7;
  localparam int CTRL_ARM = 6;
  localparam int CTRL_TAG = 5;
  localparam int CTRL_BRK = 4;
  localparam int TRIG_QUAL = 7;
  localparam int TRIG_BEGIN = 6;
  localparam int STAT_AF = 7;
  localparam int STAT_BF = 6;
  localparam int STAT_ARMED_FLAG = 5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TRIG = 1;
  localparam int IRQ_BRK = 2;
  localparam logic [7:0] TRIG_WMASK = 8'hCF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // ----------------------------------------------------------------------
  // trigger modes
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_A = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EV_B = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EV_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B = 4'h5;
  localparam logic [3:0] MODE_A_NOT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;
  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 16;
  localparam int CNT_W = 4;
endpackage : dtg_pkg

// ==== dtg_top.sv ====
/*
 * dtg_top: trigger selection, run control, status, capture store and
 * interrupt of the on-chip debug module.
 * Assumes: comparator matches and opcode-tracking results arrive as
 * one-cycle pulses from logic on clk_sys; the register port follows the
 * plain strobe protocol with read data one cycle after the read strobe.
 * The comparators, their read/write qualifiers and the opcode tracking
 * sit outside; only their results and the two compare values reach this block. An unarmed read of
 * the store low byte loads no profiling sample, and the secure inhibit
 * of the enable bit is not modelled. Store reads while armed never
 * advance the head, so the host waits for the run to end.
 */
// The register addresses and the address-and-strobe port were decided locally.
// Contract
// - trigger config writable only unarmed; bits 4,5 zero
// - tag qualifies matches by opcode execution
// - direction bit picks end or begin trace
// - event-only modes always run as begin trace
// - mode field decodes the seven pair modes
// - modes seven, eight compare address range
// - modes nine to fifteen never trigger
// - status A flag cleared on run, set on A
// - status B flag cleared on run, set on B
// - armed flag mirrors arm while enabled
// - run ends on full or on trigger
// - clearing arm or enable stops run at once
// - count cleared on run, holds valid words
// - count does not decrement on reads
// - break on trigger (end) or full (begin)
// - event-only words keep high byte zero
`timescale 1ns/10ps
module dtg_top #(
  parameter int DEPTH = dtg_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic acc_valid,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0] acc_data,
  input wire logic match_a,
  input wire logic match_b,
  input wire logic exec_valid,
  input wire logic [15:0] exec_addr,
  input wire logic exec_a,
  input wire logic exec_b,
  input wire logic [15:0] cmp_a_val,
  input wire logic [15:0] cmp_b_val,
  input wire logic cof_valid,
  input wire logic [15:0] cof_addr,
  output logic brk_req,
  output logic brk_tag,
  output logic armed,
  output logic irq
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // one-hot: PRE waits for the trigger, STORE fills after it
  typedef enum logic [2:0] {
    DTG_IDLE = 3'b001,
    DTG_PRE = 3'b010,
    DTG_STORE = 3'b100
  } dtg_run_t;

  dtg_run_t run_r;
  dtg_run_t run_nxt;
  logic en_r;
  logic tag_r;
  logic break_request_enable_r;
  logic [7:0] trig_cfg_r;
  logic af_r;
  logic bf_r;
  // A hit seen since arming, for the A-then-B modes
  logic a_seen_r;
  logic [dtg_pkg::CNT_W-1:0] cnt_r;
  logic cnt_live_r;
  logic [2:0] irq_st_r;
  logic [2:0] irq_msk_r;
  logic [7:0] rdata_r;
  logic brk_r;

  // ----------------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------------
  // writes to read-only addresses fall through unused
  wire wr_ctrl = reg_wr && (reg_addr == dtg_pkg::ADDR_CTRL);
  wire wr_trig = reg_wr && (reg_addr == dtg_pkg::ADDR_TRIG);
  wire wr_ist = reg_wr && (reg_addr == dtg_pkg::ADDR_IRQ_ST);
  wire wr_imsk = reg_wr && (reg_addr == dtg_pkg::ADDR_IRQ_MSK);
  wire rd_flo = reg_rd && (reg_addr == dtg_pkg::ADDR_FIFO_LO);

  // control write fields used by run control
  wire w_en = reg_wdata[dtg_pkg::CTRL_EN];
  wire w_arm = reg_wdata[dtg_pkg::CTRL_ARM];

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  wire armed_w = (run_r != DTG_IDLE);
  // start only from idle; arming again is a no-op
  wire start = wr_ctrl && w_en && w_arm && !armed_w;
  // a zero written to arm or enable ends the run without a break
  wire stop_sw = wr_ctrl && (!w_en || !w_arm);

  // frozen while armed, so stable through a run
  wire [3:0] mode = trig_cfg_r[3:0];
  wire qual_tag = trig_cfg_r[dtg_pkg::TRIG_QUAL];

  // tag mode waits for execution, force mode takes the access
  wire hit_a = qual_tag ? exec_a : match_a;
  wire hit_b = qual_tag ? exec_b : match_b;
  wire pos_valid = qual_tag ? exec_valid : acc_valid;
  wire [15:0] pos_addr = qual_tag ? exec_addr : acc_addr;

  logic trig_w;
  logic ev_only;
  logic store_ev;

  // decoder sees the qualified pulses, as the flags do
  dtg_trig_decode u_dec (
    .mode(mode),
    .hit_a(hit_a),
    .hit_b(hit_b),
    .a_seen(a_seen_r),
    .pos_valid(pos_valid),
    .pos_addr(pos_addr),
    .val_a(cmp_a_val),
    .val_b(cmp_b_val),
    .trig(trig_w),
    .event_only(ev_only),
    .store_evt(store_ev)
  );

  // event-only modes ignore the direction bit
  wire begin_tr = trig_cfg_r[dtg_pkg::TRIG_BEGIN] | ev_only;
  // decoder fires unarmed too; only armed triggers count
  wire trig_ok = trig_w && armed_w;

  // ----------------------------------------------------------------------
  // capture store
  // ----------------------------------------------------------------------
  logic [15:0] fifo_head;
  logic [dtg_pkg::CNT_W-1:0] fifo_cnt;
  logic fifo_full;

  logic end_now;
  wire in_pre = (run_r == DTG_PRE);
  wire in_store = (run_r == DTG_STORE);

  // high byte zero for event-only captures
  wire [15:0] ev_word = {8'h00, acc_data};
  // end trace: every flow change until the trigger
  wire st_circ = in_pre && !begin_tr;
  // begin trace: from the trigger cycle onwards
  wire st_first = in_pre && begin_tr && trig_w;
  wire st_norm = cof_valid && !ev_only && (st_circ || st_first || in_store);
  wire st_ev = store_ev && armed_w;
  wire fifo_wr = (st_norm || st_ev) && !end_now;
  // event-only words carry access data, others the flow address
  wire [15:0] fifo_wd = ev_only ? ev_word : cof_addr;
  // reads while armed would disturb capture sequencing, so they are dropped without advancing the head
  wire fifo_rd = rd_flo && !armed_w;

  // the start write itself empties the store
  dtg_fifo #(
    .DEPTH(DEPTH),
    .WIDTH(dtg_pkg::FIFO_WIDTH),
    .CW(dtg_pkg::CNT_W)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(start),
    .wr(fifo_wr),
    .wdata(fifo_wd),
    .rd(fifo_rd),
    .head(fifo_head),
    .count(fifo_cnt),
    .full(fifo_full)
  );

  // ----------------------------------------------------------------------
  // run completion
  // ----------------------------------------------------------------------
  // begin trace ends when the store fills; end trace ends on trigger
  wire done_full = (run_r == DTG_STORE) && begin_tr && fifo_full;
  wire done_trig = (run_r == DTG_PRE) && !begin_tr && trig_w;
  wire done = done_full || done_trig;
  // break follows completion, never a manual stop
  wire brk_fire = break_request_enable_r && done;

  always_comb begin
    end_now = done_full;
    run_nxt = run_r;
    case (run_r)
      DTG_IDLE: begin
        if (start) run_nxt = DTG_PRE;
      end
      DTG_PRE: begin
        if (done_trig) run_nxt = DTG_IDLE;
        else if (begin_tr && trig_w) run_nxt = DTG_STORE;
      end
      DTG_STORE: begin
        if (done_full) run_nxt = DTG_IDLE;
      end
      default: run_nxt = DTG_IDLE;
    endcase
    // a stop write wins over any other next state; a same-cycle completion still raises done and break
    if (stop_sw && armed_w) run_nxt = DTG_IDLE;
  end

  // armed is the run state itself, so it clears on completion
  always_ff @(posedge clk_sys) begin
    if (rst) run_r <= DTG_IDLE;
    else run_r <= run_nxt;
  end

  // ----------------------------------------------------------------------
  // control and trigger configuration registers
  // ----------------------------------------------------------------------
  // enable, tag and break enable follow every control write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_r <= 1'b0;
      tag_r <= 1'b0;
      break_request_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      en_r <= w_en;
      tag_r <= reg_wdata[dtg_pkg::CTRL_TAG];
      break_request_enable_r <= reg_wdata[dtg_pkg::CTRL_BRK];
    end
  end

  // bits 5:4 masked on write, so they read as zero
  always_ff @(posedge clk_sys) begin
    if (rst) trig_cfg_r <= dtg_pkg::RST_BYTE;
    else if (wr_trig && !armed_w) trig_cfg_r <= reg_wdata & dtg_pkg::TRIG_WMASK;
  end

  // ----------------------------------------------------------------------
  // match flags and sequence memory
  // ----------------------------------------------------------------------
  // flags take only qualified hits inside a run
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      af_r <= 1'b0;
      bf_r <= 1'b0;
      a_seen_r <= 1'b0;
    end else if (start) begin
      af_r <= 1'b0;
      bf_r <= 1'b0;
      a_seen_r <= 1'b0;
    end else if (armed_w) begin
      if (hit_a) af_r <= 1'b1;
      if (hit_b) bf_r <= 1'b1;
      if (hit_a) a_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // valid count: follows the store while armed, then freezes
  // ----------------------------------------------------------------------
  // cnt_live_r catches the last word after the run ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
      cnt_live_r <= 1'b0;
    end else begin
      cnt_live_r <= armed_w;
      if (start) cnt_r <= '0;
      else if (armed_w || cnt_live_r) cnt_r <= fifo_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt: sticky, write one to clear, a new event wins
  // ----------------------------------------------------------------------
  // a manual stop raises neither done nor break
  wire [2:0] irq_ev = {brk_fire, trig_ok, done};
  wire [2:0] irq_clr = wr_ist ? reg_wdata[2:0] : 3'h0;
  wire [2:0] irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_st_r <= dtg_pkg::IRQ_RST;
      irq_msk_r <= dtg_pkg::IRQ_RST;
    end else begin
      irq_st_r <= irq_st_nxt;
      if (wr_imsk) irq_msk_r <= reg_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------------
  // break request
  // ----------------------------------------------------------------------
  // registered: the break leaves one cycle after completion
  always_ff @(posedge clk_sys) begin
    if (rst) brk_r <= 1'b0;
    else brk_r <= brk_fire;
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // armed image reads zero while disabled
  wire armed_flag = armed_w && en_r;
  wire [7:0] ctrl_rd = {en_r, armed_w, tag_r, break_request_enable_r, 4'h0};
  wire [7:0] stat_rd = {af_r, bf_r, armed_flag, 1'b0, cnt_r};
  logic [7:0] rd_mux;

  // unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      dtg_pkg::ADDR_CTRL: rd_mux = ctrl_rd;
      dtg_pkg::ADDR_TRIG: rd_mux = trig_cfg_r;
      dtg_pkg::ADDR_STAT: rd_mux = stat_rd;
      dtg_pkg::ADDR_FIFO_HI: rd_mux = fifo_head[15:8];
      dtg_pkg::ADDR_FIFO_LO: rd_mux = fifo_head[7:0];
      dtg_pkg::ADDR_IRQ_ST: rd_mux = {5'h00, irq_st_r};
      dtg_pkg::ADDR_IRQ_MSK: rd_mux = {5'h00, irq_msk_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // idle cycles return zero, never stale data
  always_ff @(posedge clk_sys) begin
    if (rst) rdata_r <= 8'h00;
    else if (reg_rd) rdata_r <= rd_mux;
    else rdata_r <= 8'h00;
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign brk_req = brk_r;
  // tag type passed through for the core's break kind
  assign brk_tag = tag_r;
  assign armed = armed_w;
  assign irq = |(irq_st_r & irq_msk_r);
endmodule : dtg_top

// ==== dtg_top_properties.sv ====
/* dtg_top_chk: port-level assertions for dtg_top, bound to every instance.
   Assumes: single clk_sys domain, synchronous active-high rst. */
`timescale 1ns/10ps
module dtg_top_chk #(
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic brk_req,
  input wire logic armed
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------------
  // steps
  // ----------------------------------------------------------------------
  sequence s_rd_of(logic [2:0] a);
    $past(reg_rd) && $past(reg_addr) == a;
  endsequence
  sequence s_ctrl_wr;
    reg_wr && reg_addr == dtg_pkg::ADDR_CTRL;
  endsequence
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_trig_reserved: assert property (s_rd_of(dtg_pkg::ADDR_TRIG) |-> reg_rdata[5:4] == 2'h0)
    else $error("trigger config bits 5:4 not zero");
  chk_armed_flag_idle: assert property (s_rd_of(dtg_pkg::ADDR_STAT) ##0 !$past(armed) |-> !reg_rdata[5])
    else $error("armed flag set while idle");
  chk_count_range: assert property (s_rd_of(dtg_pkg::ADDR_STAT) |-> reg_rdata[3:0] <= DEPTH)
    else $error("valid count above depth");
  chk_run_start: assert property (s_ctrl_wr ##0 reg_wdata[7:6] == 2'h3 && !armed |=> armed)
    else $error("arm write did not start run");
  chk_run_stop: assert property (s_ctrl_wr ##0 reg_wdata[7:6] != 2'h3 |=> !armed)
    else $error("clearing arm or enable did not stop run");
  chk_armed_cause: assert property (!armed && !reg_wr |=> !armed)
    else $error("run started without a control write");
  chk_brk_pulse: assert property (brk_req |=> !brk_req)
    else $error("break request longer than one cycle");
  chk_brk_at_end: assert property (brk_req |-> $fell(armed))
    else $error("break request without run completion");
endmodule : dtg_top_chk

bind dtg_top dtg_top_chk #(.DEPTH(DEPTH)) u_dtg_top_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .brk_req, .armed);

// ==== dtg_trig_decode.sv ====
/*
 * dtg_trig_decode: combinational trigger-mode decoder.
 * Assumes: hits are already qualified (force or tag) by the caller.
 */
`timescale 1ns/10ps
module dtg_trig_decode (
  mode,
  hit_a,
  hit_b,
  a_seen,
  pos_valid,
  pos_addr,
  val_a,
  val_b,
  trig,
  event_only,
  store_evt
);
  input wire logic [3:0] mode;
  input wire logic hit_a;
  input wire logic hit_b;
  input wire logic a_seen;
  input wire logic pos_valid;
  input wire logic [15:0] pos_addr;
  input wire logic [15:0] val_a;
  input wire logic [15:0] val_b;
  output logic trig;
  output logic event_only;
  output logic store_evt;

  wire in_rng = (pos_addr >= val_a) && (pos_addr <= val_b);

  always_comb begin
    trig = 1'b0;
    case (mode)
      dtg_pkg::MODE_A: trig = hit_a;
      dtg_pkg::MODE_A_OR_B: trig = hit_a | hit_b;
      dtg_pkg::MODE_A_THEN_B: trig = a_seen & hit_b;
      dtg_pkg::MODE_EV_B: trig = hit_b;
      dtg_pkg::MODE_A_THEN_EV_B: trig = a_seen & hit_b;
      dtg_pkg::MODE_A_AND_B: trig = hit_a & hit_b;
      dtg_pkg::MODE_A_NOT_B: trig = hit_a & ~hit_b;
      dtg_pkg::MODE_INSIDE: trig = pos_valid & in_rng;
      dtg_pkg::MODE_OUTSIDE: trig = pos_valid & ~in_rng;
      default: trig = 1'b0;
    endcase
  end

  // event-only modes store a byte per qualifying B event
  assign event_only = (mode == dtg_pkg::MODE_EV_B) || (mode == dtg_pkg::MODE_A_THEN_EV_B);
  assign store_evt = event_only & trig;
endmodule : dtg_trig_decode

// ==== test_debug_trigger_status_logic.sv ====
/* test_debug_trigger_status_logic: self-checking bench for dtg_top.
   Assumes: dtg_cpu_model drives the CPU side, checker bound in its own file. */
`timescale 1ns/10ps
module test_debug_trigger_status_logic;
  logic clk_sys, rst, reg_wr, reg_rd, go;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, acc_data;
  logic [4:0] kind;
  logic [15:0] addr, cmp_a_val, cmp_b_val, acc_addr, exec_addr, cof_addr;
  logic acc_valid, match_a, match_b, exec_valid, exec_a, exec_b, cof_valid, brk_req, brk_tag, armed, irq;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_brk = 0;
  logic [3:0] t_mode [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [4:0] t_k1 [8] = '{5'h02, 5'h08, 5'h01, 5'h01, 5'h03, 5'h10, 5'h10, 5'h01};
  logic [4:0] t_k2 [8] = '{5'h01, 5'h02, 5'h02, 5'h03, 5'h01, 5'h10, 5'h10, 5'h03};
  logic [15:0] t_a1 [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2001, 16'h2000, 16'h0};
  logic [15:0] t_a2 [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1000, 16'h0FFF, 16'h0};

  dtg_top u_dtg_top (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_valid,
    .acc_addr, .acc_data, .match_a, .match_b, .exec_valid, .exec_addr, .exec_a, .exec_b, .cmp_a_val,
    .cmp_b_val, .cof_valid, .cof_addr, .brk_req, .brk_tag, .armed, .irq);
  dtg_cpu_model u_dtg_cpu_model (.clk_sys, .rst, .go, .kind, .addr, .acc_valid, .acc_addr, .acc_data,
    .match_a, .match_b, .exec_valid, .exec_addr, .exec_a, .exec_b, .cof_valid, .cof_addr);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // counted mid-cycle, away from the edge that launches it
  always @(negedge clk_sys) if (brk_req === 1'b1) n_brk <= n_brk + 1;
  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string name);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(name, {8'h00, reg_rdata}, {8'h00, e});
    @(posedge clk_sys);
  endtask : rdc
  task automatic ev(input logic [4:0] k, input logic [15:0] a);
    kind <= k;
    addr <= a;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
  endtask : ev
  task automatic arm_idle(input logic [7:0] trig, input logic [7:0] ctrl);
    wr(dtg_pkg::ADDR_TRIG, trig);
    wr(dtg_pkg::ADDR_CTRL, ctrl);
  endtask : arm_idle
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_regs;
    rdc(dtg_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
    rdc(dtg_pkg::ADDR_STAT, 8'h00, "status reset");
    rdc(3'h7, 8'h00, "unmapped");
    arm_idle(8'hFF, 8'hE0);
    chk("brk tag", {15'h0, brk_tag}, 16'h0001);
    wr(dtg_pkg::ADDR_TRIG, 8'h00);
    rdc(dtg_pkg::ADDR_TRIG, 8'hCF, "trig locked");
    ev(5'h07, 16'h0100);
    repeat (2) @(posedge clk_sys);
    rdc(dtg_pkg::ADDR_STAT, 8'hE0, "mode f flags");
    wr(dtg_pkg::ADDR_CTRL, 8'h80);
    rdc(dtg_pkg::ADDR_STAT, 8'hC0, "manual stop");
  endtask : s_regs
  task automatic s_modes;
    for (int i = 0; i < 8; i++) begin
      arm_idle({4'h0, t_mode[i]}, 8'hC0);
      ev(t_k1[i], t_a1[i]);
      repeat (2) @(posedge clk_sys);
      chk("mode first", {15'h0, armed}, 16'h0001);
      ev(t_k2[i], t_a2[i]);
      repeat (2) @(posedge clk_sys);
      chk("mode second", {15'h0, armed}, 16'(t_mode[i] > 4'h8));
      wr(dtg_pkg::ADDR_CTRL, 8'h40);
    end
  endtask : s_modes
  task automatic s_irq;
    chk("irq masked", {15'h0, irq}, 16'h0000);
    rdc(dtg_pkg::ADDR_IRQ_ST, 8'h03, "irq status");
    wr(dtg_pkg::ADDR_IRQ_MSK, 8'h02);
    chk("irq unmasked", {15'h0, irq}, 16'h0001);
    wr(dtg_pkg::ADDR_IRQ_ST, 8'h03);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    wr(dtg_pkg::ADDR_IRQ_MSK, 8'h07);
  endtask : s_irq
  task automatic s_tag;
    arm_idle(8'h80, 8'hC0);
    ev(5'h01, 16'h0042);
    repeat (2) @(posedge clk_sys);
    chk("tag access only", {15'h0, armed}, 16'h0001);
    ev(5'h05, 16'h0042);
    repeat (2) @(posedge clk_sys);
    chk("tag executed", {15'h0, armed}, 16'h0000);
  endtask : s_tag
  task automatic s_end_trace;
    int b;
    b = n_brk;
    wr(dtg_pkg::ADDR_IRQ_ST, 8'h07);
    chk("irq before end", {15'h0, irq}, 16'h0000);
    arm_idle(8'h00, 8'hD0);
    for (int i = 0; i < 10; i++) ev(5'h08, 16'h1200 + 16'(i));
    ev(5'h01, 16'h0042);
    repeat (2) @(posedge clk_sys);
    chk("end brk", 16'(n_brk - b), 16'h0001);
    chk("end irq", {15'h0, irq}, 16'h0001);
    rdc(dtg_pkg::ADDR_IRQ_ST, 8'h07, "end irq status");
    rdc(dtg_pkg::ADDR_STAT, 8'h88, "end status");
    // host counts words itself, the status count never moves
    for (int i = 2; i < 10; i++) begin
      rdc(dtg_pkg::ADDR_FIFO_HI, 8'h12, "fifo hi");
      rdc(dtg_pkg::ADDR_FIFO_LO, 8'(i), "fifo lo");
    end
    rdc(dtg_pkg::ADDR_STAT, 8'h88, "count after drain");
  endtask : s_end_trace
  task automatic s_begin_trace;
    int b;
    b = n_brk;
    arm_idle(8'h40, 8'hD0);
    rdc(dtg_pkg::ADDR_STAT, 8'h20, "run start");
    for (int i = 0; i < 3; i++) ev(5'h08, 16'h3300);
    ev(5'h02, 16'h0001);
    rdc(dtg_pkg::ADDR_STAT, 8'h60, "before trigger");
    for (int i = 0; i < 8; i++) ev(i == 0 ? 5'h09 : 5'h08, 16'h3400 + 16'(i));
    repeat (2) @(posedge clk_sys);
    chk("begin brk", 16'(n_brk - b), 16'h0001);
    rdc(dtg_pkg::ADDR_STAT, 8'hC8, "begin status");
    rdc(dtg_pkg::ADDR_FIFO_HI, 8'h34, "first hi");
    rdc(dtg_pkg::ADDR_FIFO_LO, 8'h00, "first lo");
  endtask : s_begin_trace
  task automatic s_event;
    arm_idle(8'h03, 8'hD0);
    for (int i = 0; i < 8; i++) ev(5'h02, 16'h5A30 + 16'(i));
    repeat (2) @(posedge clk_sys);
    rdc(dtg_pkg::ADDR_STAT, 8'h48, "event status");
    rdc(dtg_pkg::ADDR_FIFO_HI, 8'h00, "event hi");
    rdc(dtg_pkg::ADDR_FIFO_LO, 8'h30, "event lo");
    arm_idle(8'h04, 8'hC0);
    ev(5'h02, 16'h0011);
    ev(5'h01, 16'h0000);
    ev(5'h02, 16'h0022);
    wr(dtg_pkg::ADDR_CTRL, 8'h80);
    rdc(dtg_pkg::ADDR_STAT, 8'hC1, "a then event b");
    rdc(dtg_pkg::ADDR_FIFO_LO, 8'h22, "a then b word");
  endtask : s_event
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  initial begin
    rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    kind = 5'h00;
    addr = 16'h0000;
    cmp_a_val = 16'h1000;
    cmp_b_val = 16'h2000;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    s_regs();
    s_modes();
    s_irq();
    s_tag();
    s_end_trace();
    s_begin_trace();
    s_event();
    end_sim();
  end
  // whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
endmodule : test_debug_trigger_status_logic
